/* logic/dma_cmd_defs.svh */
`ifndef DMA_CMD_DEFS_SVH
`define DMA_CMD_DEFS_SVH

// bus command codes driven on the command lines
`define CMD_MEM_READ       4'h6
`define CMD_MEM_READ_MULT  4'hC
`define CMD_MEM_READ_LINE  4'hE
`define CMD_MEM_WRITE      4'h7
`define CMD_MEM_WRITE_INV  4'hF

// configuration space offsets (byte addresses)
`define CFG_COMMAND_OFS    8'h04
`define CFG_LINE_LEN_OFS   8'h0C
`define CFG_STATUS_OFS     8'h40

// field positions, reset values and line length codes
`define CMD_INV_EN_BIT     4
`define LINE_LEN_RST       8'h00
`define LINE_LEN_SMALL     8'h08
`define LINE_LEN_LARGE     8'h10
`define LINE_DW_SMALL      5'h08
`define LINE_DW_LARGE      5'h10
`define BE_ALL_ON_N        4'h0

// buffer shape
`define RX_FIFO_WIDTH      32
`define RX_FIFO_DEPTH      16
`define RX_FIFO_AW         4

`endif

/* logic/dma_cmd_pkg.sv */
package dma_cmd_pkg;

	// path sequencer states, gray along idle-plan-request-data
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PLAN = 2'b01,
		ST_REQ  = 2'b11,
		ST_DATA = 2'b10
	} path_state_t;

endpackage : dma_cmd_pkg

/* logic/dma_fifo_mem.sv */
`timescale 1ns/1ns
// simple dual port store, read data registered
module dma_fifo_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata_r
);

	logic [WIDTH-1:0] store [DEPTH];   // word array, no reset needed

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			store[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk) begin
		rdata_r <= store[raddr];
	end

endmodule : dma_fifo_mem

/* logic/dma_fifo.sv */
`timescale 1ns/1ns
// show-ahead fifo on top of a registered-read store
module dma_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready,
	output logic      [AW:0]      count
);

	logic [AW-1:0] wr_ptr_r;    // next slot to fill
	logic [AW-1:0] rd_ptr_r;    // head slot
	logic [AW:0]   count_r;     // words held
	logic          push_d_r;    // word written last cycle, not yet readable
	logic          push;
	logic          pop;
	logic [AW-1:0] raddr;

	// a fresh word lands one edge before the read register can show it
	assign in_ready  = count_r < (AW+1)'(DEPTH);
	assign out_valid = count_r > {{AW{1'b0}}, push_d_r};
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign raddr     = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	assign count     = count_r;

	// pointers and level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			push_d_r <= 1'b0;
		end else begin
			push_d_r <= push;
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	dma_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk     (clk),
		.we      (push),
		.waddr   (wr_ptr_r),
		.wdata   (in_data),
		.raddr   (raddr),
		.rdata_r (out_data)
	);

endmodule : dma_fifo

/* logic/pci_dma_command_select.sv */
// Function
// - burst from mid line reaching line boundary uses read line
// - burst ending before boundary uses plain read
// - tx fifo almost full ends at boundary
// - whole line fetches use read multiple
// - unaligned start: read line, then multiple or plain read for the rest
// - write-invalidate drives every byte enable
// - cross boundary only writing whole next line
// - write-invalidate uses linear burst order only
// - write-invalidate needs line length 8 or 16
// - needs aligned address and full line buffered
// - write-invalidate needs command bit 4 set
// - any unmet condition falls back to write
// - condition lost mid-burst ends at line close
// - read commands on tx, invalidate on rx
`timescale 1ns/1ns
`include "dma_cmd_defs.svh"
module pci_dma_command_select
	import dma_cmd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        cfg_we,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be_n,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	input  wire logic        tx_start,
	input  wire logic [31:0] tx_addr,
	input  wire logic [11:0] tx_len,
	input  wire logic        tx_almost_full,
	output logic             tx_busy,
	output logic             rd_req,
	input  wire logic        rd_gnt,
	output logic      [3:0]  rd_cmd,
	output logic      [31:0] rd_addr,
	output logic      [11:0] rd_len,
	input  wire logic        rd_beat,
	output logic             rd_last,
	input  wire logic        rx_start,
	input  wire logic [31:0] rx_addr,
	input  wire logic [11:0] rx_len,
	input  wire logic [3:0]  rx_tail_be_n,
	output logic             rx_busy,
	input  wire logic        rx_in_valid,
	input  wire logic [31:0] rx_in_data,
	output logic             rx_in_ready,
	output logic             wr_req,
	input  wire logic        wr_gnt,
	output logic      [3:0]  wr_cmd,
	output logic      [31:0] wr_addr,
	output logic      [11:0] wr_len,
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic      [31:0] wr_data,
	output logic      [3:0]  wr_be_n,
	output logic             wr_last
);

	////////////////////////////////////////////////////////////////////
	// shared arithmetic

	// usable line length in dwords; other sizes disable line commands
	function automatic logic [4:0] line_dw(input logic [7:0] cls);
		case (cls)
			`LINE_LEN_SMALL: line_dw = `LINE_DW_SMALL;
			`LINE_LEN_LARGE: line_dw = `LINE_DW_LARGE;
			default:         line_dw = 5'h00;
		endcase
	endfunction : line_dw

	// offset mask within a line
	function automatic logic [11:0] line_mask(input logic [4:0] l);
		line_mask = {7'h00, l} - 12'h001;
	endfunction : line_mask

	// dwords from address up to the next line boundary
	function automatic logic [11:0] to_bound(input logic [29:0] a,
	                                         input logic [4:0]  l);
		to_bound = {7'h00, l} - ({8'h00, a[3:0]} & line_mask(l));
	endfunction : to_bound

	// true when the dword at a is the last of its line
	function automatic logic at_bound(input logic [29:0] a,
	                                  input logic [4:0]  l);
		at_bound = ((a[3:0] + 4'h1) & (l[3:0] - 4'h1)) == 4'h0;
	endfunction : at_bound

	////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0]  cache_line_length_r; // line length in dwords
	logic        inv_en_r;            // write-invalidate enable
	logic [4:0]  line;                // decoded line length
	logic [4:0]  fifo_cnt;            // rx buffer level
	logic        rx_mwi;              // current rx burst invalidates
	logic [31:0] cfg_rdata_r;

	assign line      = line_dw(cache_line_length_r);
	assign cfg_rdata = cfg_rdata_r;

	// host writes, lane 0 carries both fields
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cache_line_length_r <= `LINE_LEN_RST;
			inv_en_r            <= 1'b0;
		end else if (cfg_we && !cfg_be_n[0]) begin
			if (cfg_addr == `CFG_LINE_LEN_OFS) begin
				cache_line_length_r <= cfg_wdata[7:0];
			end
			if (cfg_addr == `CFG_COMMAND_OFS) begin
				inv_en_r <= cfg_wdata[`CMD_INV_EN_BIT];
			end
		end
	end

	// registered read mux; unmapped offsets read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rdata_r <= 32'h0000_0000;
		end else begin
			case (cfg_addr)
				`CFG_LINE_LEN_OFS: cfg_rdata_r <= {24'h0, cache_line_length_r};
				`CFG_COMMAND_OFS:
					cfg_rdata_r <= 32'(inv_en_r) << `CMD_INV_EN_BIT;
				`CFG_STATUS_OFS:
					cfg_rdata_r <= {24'h0, fifo_cnt, rx_mwi, rx_busy, tx_busy};
				default:           cfg_rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit fetch path

	path_state_t tx_st_r;       // tx sequencer
	logic [29:0] tx_ptr_r;      // next dword to fetch
	logic [11:0] tx_left_r;     // dwords still to fetch
	logic [11:0] tx_blen_r;     // beats left in this burst
	logic [29:0] rd_base_r;     // burst start address
	logic [3:0]  rd_cmd_r;
	logic [11:0] rd_len_r;
	logic [4:0]  tx_line_r;     // line length seen at planning
	logic [3:0]  tx_cmd_nxt;
	logic [11:0] tx_len_nxt;
	logic [11:0] tx_tb;

	assign tx_tb   = to_bound(tx_ptr_r, line);
	assign tx_busy = tx_st_r != ST_IDLE;
	assign rd_req  = tx_st_r == ST_REQ;
	assign rd_cmd  = rd_cmd_r;
	assign rd_addr = {rd_base_r, 2'b00};
	assign rd_len  = rd_len_r;

	// an almost full fifo cuts a multiple-line fetch at the line end
	assign rd_last = (tx_st_r == ST_DATA) && rd_beat &&
		((tx_blen_r == 12'h001) ||
		 ((rd_cmd_r == `CMD_MEM_READ_MULT) && tx_almost_full &&
		  at_bound(tx_ptr_r, tx_line_r)));

	// choose the read command for the next burst
	always_comb begin
		tx_cmd_nxt = `CMD_MEM_READ;
		tx_len_nxt = tx_left_r;
		if (line == 5'h00) begin
			tx_cmd_nxt = `CMD_MEM_READ;
		end else if (tx_left_r < tx_tb) begin
			// ends short of the boundary
			tx_cmd_nxt = `CMD_MEM_READ;
		end else if (tx_tb != {7'h00, line}) begin
			// unaligned head first runs up to the boundary
			tx_cmd_nxt = `CMD_MEM_READ_LINE;
			tx_len_nxt = tx_tb;
		end else begin
			// aligned: as many whole lines as remain
			tx_cmd_nxt = `CMD_MEM_READ_MULT;
			tx_len_nxt = tx_left_r & ~line_mask(line);
		end
	end

	// tx sequencer; no new burst while the fifo is almost full
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r   <= ST_IDLE;
			tx_ptr_r  <= 30'h0;
			tx_left_r <= 12'h000;
			tx_blen_r <= 12'h000;
			rd_base_r <= 30'h0;
			rd_cmd_r  <= `CMD_MEM_READ;
			rd_len_r  <= 12'h000;
			tx_line_r <= 5'h00;
		end else begin
			case (tx_st_r)
				ST_IDLE: begin
					if (tx_start && tx_len != 12'h000) begin
						tx_ptr_r  <= tx_addr[31:2];
						tx_left_r <= tx_len;
						tx_st_r   <= ST_PLAN;
					end
				end
				ST_PLAN: begin
					if (!tx_almost_full) begin
						rd_cmd_r  <= tx_cmd_nxt;
						rd_len_r  <= tx_len_nxt;
						tx_blen_r <= tx_len_nxt;
						rd_base_r <= tx_ptr_r;
						tx_line_r <= line;
						tx_st_r   <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (rd_gnt) begin
						tx_st_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (rd_beat) begin
						tx_ptr_r  <= tx_ptr_r + 30'h1;
						tx_left_r <= tx_left_r - 12'h001;
						tx_blen_r <= tx_blen_r - 12'h001;
						if (rd_last) begin
							tx_st_r <= (tx_left_r == 12'h001) ? ST_IDLE : ST_PLAN;
						end
					end
				end
				default: tx_st_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// receive write path

	path_state_t rx_st_r;       // rx sequencer
	logic [29:0] rx_ptr_r;      // next dword to write
	logic [11:0] rx_left_r;     // dwords still to write
	logic [11:0] rx_blen_r;     // beats left in this burst
	logic [29:0] wr_base_r;
	logic [3:0]  wr_cmd_r;
	logic [11:0] wr_len_r;
	logic [3:0]  tail_be_n_r;   // byte enables of the last dword
	logic [4:0]  rx_line_r;
	logic [11:0] rx_tb;
	logic        mwi_ok;        // every invalidate condition holds now
	logic        mwi_keep;      // may run into the next whole line
	logic        wr_beat;
	logic        wr_fire_last;

	assign rx_tb   = to_bound(rx_ptr_r, line);
	assign rx_busy = rx_st_r != ST_IDLE;
	assign rx_mwi  = wr_cmd_r == `CMD_MEM_WRITE_INV;
	assign wr_req  = rx_st_r == ST_REQ;
	assign wr_cmd  = wr_cmd_r;
	assign wr_addr = {wr_base_r, 2'b00};
	assign wr_len  = wr_len_r;

	// line length, alignment, buffered line, enable bit, whole line left
	assign mwi_ok = inv_en_r && (line != 5'h00) &&
		(rx_tb == {7'h00, line}) && (fifo_cnt >= line) &&
		(rx_left_r >= {7'h00, line});

	// at a line end, continue only with the next line fully assured
	assign mwi_keep = inv_en_r && (line == rx_line_r) &&
		(fifo_cnt > rx_line_r) &&
		(rx_left_r > {7'h00, rx_line_r});

	assign wr_beat  = (rx_st_r == ST_DATA) && wr_valid && wr_ready;
	assign wr_fire_last = (rx_blen_r == 12'h001) ||
		(rx_mwi && at_bound(rx_ptr_r, rx_line_r) && !mwi_keep);
	assign wr_last  = wr_beat && wr_fire_last;

	// invalidate bursts keep every lane on; a write may trim its tail
	assign wr_be_n = (!rx_mwi && rx_left_r == 12'h001) ?
		tail_be_n_r : `BE_ALL_ON_N;

	// rx sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_r     <= ST_IDLE;
			rx_ptr_r    <= 30'h0;
			rx_left_r   <= 12'h000;
			rx_blen_r   <= 12'h000;
			wr_base_r   <= 30'h0;
			wr_cmd_r    <= `CMD_MEM_WRITE;
			wr_len_r    <= 12'h000;
			tail_be_n_r <= `BE_ALL_ON_N;
			rx_line_r   <= 5'h00;
		end else begin
			case (rx_st_r)
				ST_IDLE: begin
					if (rx_start && rx_len != 12'h000) begin
						rx_ptr_r    <= rx_addr[31:2];
						rx_left_r   <= rx_len;
						tail_be_n_r <= rx_tail_be_n;
						rx_st_r     <= ST_PLAN;
					end
				end
				ST_PLAN: begin
					wr_base_r <= rx_ptr_r;
					rx_line_r <= line;
					rx_st_r   <= ST_REQ;
					if (mwi_ok) begin
						// advertise all whole lines; cut at a line end unless mwi_keep holds
						wr_cmd_r  <= `CMD_MEM_WRITE_INV;
						wr_len_r  <= rx_left_r & ~line_mask(line);
						rx_blen_r <= rx_left_r & ~line_mask(line);
					end else if (line != 5'h00 && rx_tb < rx_left_r) begin
						// partial line: plain write up to the boundary
						wr_cmd_r  <= `CMD_MEM_WRITE;
						wr_len_r  <= rx_tb;
						rx_blen_r <= rx_tb;
					end else begin
						wr_cmd_r  <= `CMD_MEM_WRITE;
						wr_len_r  <= rx_left_r;
						rx_blen_r <= rx_left_r;
					end
				end
				ST_REQ: begin
					if (wr_gnt) begin
						rx_st_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (wr_beat) begin
						rx_ptr_r  <= rx_ptr_r + 30'h1;
						rx_left_r <= rx_left_r - 12'h001;
						rx_blen_r <= rx_blen_r - 12'h001;
						if (wr_fire_last) begin
							rx_st_r <= (rx_left_r == 12'h001) ? ST_IDLE : ST_PLAN;
						end
					end
				end
				default: rx_st_r <= ST_IDLE;
			endcase
		end
	end

	// receive data buffer; its ready stalls the upstream producer
	logic fifo_valid;
	assign wr_valid = fifo_valid && (rx_st_r == ST_DATA);

	dma_fifo #(
		.WIDTH (`RX_FIFO_WIDTH),
		.DEPTH (`RX_FIFO_DEPTH),
		.AW    (`RX_FIFO_AW)
	) u_rx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (rx_in_valid),
		.in_data   (rx_in_data),
		.in_ready  (rx_in_ready),
		.out_valid (fifo_valid),
		.out_data  (wr_data),
		.out_ready (wr_beat),
		.count     (fifo_cnt)
	);

	////////////////////////////////////////////////////////////////////
	// checks

	property p_mwi_be;
		@(posedge clk) disable iff (!rst_b)
		wr_beat && rx_mwi |-> wr_be_n == `BE_ALL_ON_N;
	endproperty
	a_mwi_be: assert property (p_mwi_be)
		else $error("invalidate data phase without all byte enables");

	property p_mwi_cfg;
		@(posedge clk) disable iff (!rst_b)
		wr_req && rx_mwi |-> inv_en_r && (line == `LINE_DW_SMALL ||
			line == `LINE_DW_LARGE);
	endproperty
	a_mwi_cfg: assert property (p_mwi_cfg)
		else $error("invalidate issued with bad line length or disabled");

	property p_mwi_buf;
		@(posedge clk) disable iff (!rst_b)
		$rose(wr_req) && rx_mwi |-> fifo_cnt >= rx_line_r &&
			(wr_base_r[3:0] & (rx_line_r[3:0] - 4'h1)) == 4'h0;
	endproperty
	a_mwi_buf: assert property (p_mwi_buf)
		else $error("invalidate without aligned address or full line");

	property p_mwi_fall;
		@(posedge clk) disable iff (!rst_b)
		rx_st_r == ST_PLAN && !inv_en_r |=> wr_cmd == `CMD_MEM_WRITE;
	endproperty
	a_mwi_fall: assert property (p_mwi_fall)
		else $error("write command not used when invalidate disabled");

	property p_mwi_cut;
		@(posedge clk) disable iff (!rst_b)
		wr_beat && rx_mwi && !inv_en_r && at_bound(rx_ptr_r, rx_line_r)
		|-> wr_last ##1 rx_st_r != ST_DATA;
	endproperty
	a_mwi_cut: assert property (p_mwi_cut)
		else $error("invalidate burst ran past line after enable lost");

	property p_linear;
		@(posedge clk) disable iff (!rst_b)
		rd_req || wr_req |-> rd_addr[1:0] == 2'b00 && wr_addr[1:0] == 2'b00;
	endproperty
	a_linear: assert property (p_linear)
		else $error("burst address not in linear order");

	property p_rd_line;
		@(posedge clk) disable iff (!rst_b)
		rd_req && rd_cmd == `CMD_MEM_READ_LINE |->
			rd_len == to_bound(rd_base_r, tx_line_r) &&
			rd_len != {7'h00, tx_line_r};
	endproperty
	a_rd_line: assert property (p_rd_line)
		else $error("read line does not end on the line boundary");

	property p_rd_short;
		@(posedge clk) disable iff (!rst_b)
		rd_req && rd_cmd == `CMD_MEM_READ && tx_line_r != 5'h00 |->
			rd_len < to_bound(rd_base_r, tx_line_r);
	endproperty
	a_rd_short: assert property (p_rd_short)
		else $error("plain read reaches the line boundary");

	property p_rd_mult;
		@(posedge clk) disable iff (!rst_b)
		rd_req && rd_cmd == `CMD_MEM_READ_MULT |->
			(rd_len & line_mask(tx_line_r)) == 12'h000 &&
			to_bound(rd_base_r, tx_line_r) == {7'h00, tx_line_r};
	endproperty
	a_rd_mult: assert property (p_rd_mult)
		else $error("read multiple not whole aligned lines");

	property p_rd_stop;
		@(posedge clk) disable iff (!rst_b)
		tx_st_r == ST_DATA && rd_beat && tx_almost_full &&
		rd_cmd == `CMD_MEM_READ_MULT && at_bound(tx_ptr_r, tx_line_r)
		|-> rd_last ##1 !rd_req;
	endproperty
	a_rd_stop: assert property (p_rd_stop)
		else $error("fetch not ended at line boundary when fifo full");

	property p_codes;
		@(posedge clk) disable iff (!rst_b)
		rd_req |-> rd_cmd != `CMD_MEM_WRITE && rd_cmd != `CMD_MEM_WRITE_INV;
	endproperty
	a_codes: assert property (p_codes)
		else $error("write command on the transmit path");

endmodule : pci_dma_command_select

/* sim/host_mem_model.sv */
`timescale 1ns/1ns
// host target stand-in: grants bursts, sources read beats, sinks writes
module host_mem_model (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic stall,
	input  wire logic rd_req,
	output logic      rd_gnt,
	output logic      rd_beat,
	input  wire logic rd_last,
	input  wire logic wr_req,
	output logic      wr_gnt,
	input  wire logic wr_valid,
	output logic      wr_ready,
	input  wire logic wr_last
);
	logic rd_act, wr_act, ph;       // open bursts, stall phase
	logic n_rg, n_rb, n_wg, n_wr;   // next drive values

	//////////////////////////////////////////////////////////////////////
	// decide on the quiet half cycle, so no race with the edge
	always @(negedge clk) begin
		if (!rst_b) begin
			{rd_act, wr_act, ph} = 3'h0;
		end else begin
			if (rd_req && rd_gnt)
				rd_act = 1'b1;
			else if (rd_beat && rd_last)
				rd_act = 1'b0;  // nothing prefetched survives a burst
			if (wr_req && wr_gnt)
				wr_act = 1'b1;
			else if (wr_valid && wr_ready && wr_last)
				wr_act = 1'b0;
			ph = !ph;           // slow mode answers every other cycle
		end
		n_rg = rst_b && rd_req && !rd_gnt && !(stall && ph);
		n_rb = rst_b && rd_act && !(stall && ph);
		n_wg = rst_b && wr_req && !wr_gnt && !(stall && ph);
		n_wr = rst_b && wr_act && !(stall && ph);
	end

	//////////////////////////////////////////////////////////////////////
	// drive just after the rising edge
	always @(posedge clk) begin
		rd_gnt   <= #1 n_rg;
		rd_beat  <= #1 n_rb;
		wr_gnt   <= #1 n_wg;
		wr_ready <= #1 n_wr;
	end
endmodule : host_mem_model

/* sim/pci_dma_command_select_tb.sv */
`timescale 1ns/1ns
`include "dma_cmd_defs.svh"
// command choice bench: config and job tasks, burst log compare
module pci_dma_command_select_tb;
	logic        clk, rst_b, stall, cfg_we;   // clock, reset, pacing
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be_n, rd_cmd, wr_cmd, wr_be_n, rx_tail_be_n;
	logic [31:0] cfg_wdata, cfg_rdata, tx_addr, rd_addr, rx_addr;
	logic [31:0] rx_in_data, wr_addr, wr_data, seq;
	logic [11:0] tx_len, rd_len, rx_len, wr_len;
	logic        tx_start, tx_almost_full, tx_busy, rd_req, rd_gnt;
	logic        rd_beat, rd_last, rx_start, rx_busy, rx_in_valid;
	logic        rx_in_ready, wr_req, wr_gnt, wr_valid, wr_ready, wr_last;
	int          err_count, tests_run, rcnt, wcnt, i;
	logic [31:0] bq[2][$];  // burst logs: 0 write, 1 read
	logic [31:0] xq[$];     // words owed to the write side

	pci_dma_command_select DUT (.clk, .rst_b, .cfg_we, .cfg_addr, .cfg_be_n,
		.cfg_wdata, .cfg_rdata, .tx_start, .tx_addr, .tx_len, .tx_almost_full,
		.tx_busy, .rd_req, .rd_gnt, .rd_cmd, .rd_addr, .rd_len, .rd_beat,
		.rd_last, .rx_start, .rx_addr, .rx_len, .rx_tail_be_n, .rx_busy,
		.rx_in_valid, .rx_in_data, .rx_in_ready, .wr_req, .wr_gnt, .wr_cmd,
		.wr_addr, .wr_len, .wr_valid, .wr_ready, .wr_data, .wr_be_n, .wr_last);
	host_mem_model host (.clk, .rst_b, .stall, .rd_req, .rd_gnt, .rd_beat,
		.rd_last, .wr_req, .wr_gnt, .wr_valid, .wr_ready, .wr_last);

	//////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// every task except check and conclude starts and ends 1 ns after a rising edge
	task cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		#1;
		cfg_we = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_be_n = be;
		@(posedge clk);
		#1;
		cfg_we = 1'b0;
	endtask : cfg_wr

	// read data lags the address by one cycle
	task cfg_rd(input logic [7:0] a, input logic [31:0] e);
		cfg_addr = a;
		@(posedge clk);
		#1;
		check(cfg_rdata, e);
	endtask : cfg_rd

	task wait_idle;
		for (i = 0; i < 3000 && (tx_busy !== 1'b0 || rx_busy !== 1'b0); i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_idle

	task job(input bit rd, input logic [31:0] a, input logic [11:0] n);
		{tx_start, tx_addr, tx_len} = {rd, a, n};
		{rx_start, rx_addr, rx_len} = {!rd, a, n};
		@(posedge clk);
		#1;
		{tx_start, rx_start} = 2'b00;
	endtask : job

	// fills the buffer, waiting on its ready under a bound
	task push(input int n);
		for (int k = 0; k < n; k++) begin
			rx_in_valid = 1'b1;
			rx_in_data = seq;
			for (i = 0; i < 100 && rx_in_ready !== 1'b1; i++) begin
				@(posedge clk);
				#1;
			end
			@(posedge clk);
			#1;
			xq.push_back(seq);
			seq++;
		end
		rx_in_valid = 1'b0;
	endtask : push

	// log entry: command, address, planned length, beats, last enables
	task exp_burst(input bit rd, input logic [3:0] c, input logic [31:0] a,
		input logic [11:0] n, input logic [11:0] b, input logic [3:0] be);
		for (i = 0; i < 3000 && bq[rd].size() < 5; i++) begin
			@(posedge clk);
			#1;
		end
		check(bq[rd].pop_front(), {28'h0, c});
		check(bq[rd].pop_front(), a);
		check(bq[rd].pop_front(), {20'h0, n});
		check(bq[rd].pop_front(), {20'h0, b});
		check(bq[rd].pop_front(), {28'h0, be});
	endtask : exp_burst

	//////////////////////////////////////////////////////////////////////
	// bus monitor, on the falling edge where everything has settled
	always @(negedge clk) begin
		if (rd_req && rd_gnt)
			bq[1].push_back({28'h0, rd_cmd});
		if (rd_req && rd_gnt)
			bq[1].push_back(rd_addr);
		if (rd_req && rd_gnt)
			bq[1].push_back({20'h0, rd_len});
		if (rd_beat)
			rcnt++;
		if (rd_beat && rd_last) begin
			bq[1].push_back(rcnt);
			bq[1].push_back(32'h0);
			rcnt = 0;
		end
		if (wr_req && wr_gnt)
			bq[0].push_back({28'h0, wr_cmd});
		if (wr_req && wr_gnt)
			bq[0].push_back(wr_addr);
		if (wr_req && wr_gnt)
			bq[0].push_back({20'h0, wr_len});
		if (wr_valid && wr_ready) begin
			wcnt++;
			check(wr_data, xq.pop_front());
			if (wr_cmd === `CMD_MEM_WRITE_INV)
				check({28'h0, wr_be_n}, 32'h0);
			if (wr_last) begin
				bq[0].push_back(wcnt);
				bq[0].push_back({28'h0, wr_be_n});
				wcnt = 0;
			end
		end
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#3000000;
		err_count++;
		conclude;
	end

	//////////////////////////////////////////////////////////////////////
	initial begin
		{cfg_we, tx_start, rx_start, rx_in_valid, tx_almost_full, stall} = 6'h0;
		{cfg_addr, cfg_be_n, cfg_wdata, tx_addr, rx_addr} = '0;
		{tx_len, rx_len, rx_in_data, err_count, tests_run, rcnt, wcnt} = '0;
		rx_tail_be_n = 4'h3;
		seq = 32'h0000_1000;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1'b1;
		cfg_rd(8'h0C, 32'h0);
		cfg_rd(8'h40, 32'h0);
		cfg_rd(8'h20, 32'h0);
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h10, 4'h0);
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h08, 4'hF);
		cfg_rd(`CFG_LINE_LEN_OFS, 32'h10);
		cfg_wr(`CFG_COMMAND_OFS, 32'hFF, 4'h0);
		cfg_rd(`CFG_COMMAND_OFS, 32'h10);
		// unaligned fetch with a slow target
		stall = 1'b1;
		job(1, 32'h44, 12'd20);
		wait_idle;
		exp_burst(1, `CMD_MEM_READ_LINE, 32'h44, 12'd15, 12'd15, 4'h0);
		exp_burst(1, `CMD_MEM_READ, 32'h80, 12'd5, 12'd5, 4'h0);
		stall = 1'b0;
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h08, 4'h0);
		job(1, 32'h100, 12'd44);
		wait_idle;
		exp_burst(1, `CMD_MEM_READ_MULT, 32'h100, 12'd40, 12'd40, 4'h0);
		exp_burst(1, `CMD_MEM_READ, 32'h1A0, 12'd4, 12'd4, 4'h0);
		// buffer pressure in mid line cuts at the line end
		job(1, 32'h200, 12'd32);
		for (i = 0; i < 200 && rcnt < 3; i++) begin
			@(posedge clk);
			#1;
		end
		tx_almost_full = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		tx_almost_full = 1'b0;
		wait_idle;
		exp_burst(1, `CMD_MEM_READ_MULT, 32'h200, 12'd32, 12'd8, 4'h0);
		exp_burst(1, `CMD_MEM_READ_MULT, 32'h220, 12'd24, 12'd24, 4'h0);
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h20, 4'h0);
		job(1, 32'h300, 12'd10);
		wait_idle;
		exp_burst(1, `CMD_MEM_READ, 32'h300, 12'd10, 12'd10, 4'h0);
		// receive: fill the buffer until it refuses
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h10, 4'h0);
		push(16);
		check({31'h0, rx_in_ready}, 32'h0);
		cfg_rd(8'h40, 32'h80);
		stall = 1'b1;
		job(0, 32'h400, 12'd16);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE_INV, 32'h400, 12'd16, 12'd16, 4'h0);
		stall = 1'b0;
		cfg_rd(8'h40, 32'h4);
		push(16);
		job(0, 32'h404, 12'd16);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE, 32'h404, 12'd15, 12'd15, 4'h0);
		exp_burst(0, `CMD_MEM_WRITE, 32'h440, 12'd1, 12'd1, 4'h3);
		cfg_wr(`CFG_COMMAND_OFS, 32'h0, 4'h0);
		push(16);
		job(0, 32'h600, 12'd16);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE, 32'h600, 12'd16, 12'd16, 4'h3);
		cfg_wr(`CFG_COMMAND_OFS, 32'h10, 4'h0);
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h08, 4'h0);
		push(8);
		job(0, 32'h800, 12'd8);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE_INV, 32'h800, 12'd8, 12'd8, 4'h0);
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h10, 4'h0);
		push(8);
		job(0, 32'hA00, 12'd8);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE, 32'hA00, 12'd8, 12'd8, 4'h3);
		// short lines with the next line buffered run on past the boundary
		cfg_wr(`CFG_LINE_LEN_OFS, 32'h08, 4'h0);
		push(16);
		job(0, 32'hC00, 12'd16);
		wait_idle;
		exp_burst(0, `CMD_MEM_WRITE_INV, 32'hC00, 12'd16, 12'd16, 4'h0);
		conclude;
	end
endmodule : pci_dma_command_select_tb
